/* File: hdl/cwg_pkg.sv */
package cwg_pkg;

   // ****************************************************************
   // Register indexes on the plain register port
   // ****************************************************************
   localparam logic [3:0] ADDR_CONTROL_ZERO   = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_ONE    = 4'h1;
   localparam logic [3:0] ADDR_CLOCK_SELECT   = 4'h2;
   localparam logic [3:0] ADDR_SOURCE_SELECT  = 4'h3;
   localparam logic [3:0] ADDR_STEERING       = 4'h4;
   localparam logic [3:0] ADDR_SHUTDOWN_ZERO  = 4'h5;
   localparam logic [3:0] ADDR_SHUTDOWN_ONE   = 4'h6;
   localparam logic [3:0] ADDR_RISING_DELAY   = 4'h7;
   localparam logic [3:0] ADDR_FALLING_DELAY  = 4'h8;
   localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h9;
   localparam logic [3:0] ADDR_IRQ_MASK       = 4'hA;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int BIT_ENABLE      = 7;
   localparam int BIT_LOAD        = 6;
   localparam int BIT_INPUT_LEVEL = 5;
   localparam int BIT_SHUTDOWN    = 7;
   localparam int BIT_RESTART     = 6;
   localparam int BIT_EVT_SHUT    = 0;
   localparam int BIT_EVT_LOAD    = 1;

   // ****************************************************************
   // Reset values and widths
   // ****************************************************************
   localparam logic [7:0] RESET_REG   = 8'h00;
   localparam int         DELAY_W     = 6;
   localparam int         NUM_SOURCES = 14;
   localparam int         NUM_SHUT    = 4;

   // ****************************************************************
   // Operating modes
   // ****************************************************************
   localparam logic [2:0] MODE_STEER      = 3'h0;
   localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
   localparam logic [2:0] MODE_FB_FWD     = 3'h2;
   localparam logic [2:0] MODE_FB_REV     = 3'h3;
   localparam logic [2:0] MODE_HALF       = 3'h4;
   localparam logic [2:0] MODE_PUSH_PULL  = 3'h5;

   // Override level codes for one output pair
   localparam logic [1:0] LEVEL_LOW  = 2'h2;
   localparam logic [1:0] LEVEL_HIGH = 2'h3;

   typedef struct packed {
      logic       enable;
      logic       buffer_load_request;
      logic [2:0] mode;
   } cwg_ctrl_t;

   typedef struct packed {
      logic       shutdown;
      logic       restart;
      logic [1:0] override_level_second_pair;
      logic [1:0] override_level_first_pair;
   } cwg_shut_t;

endpackage

/* File: hdl/cwg_control.sv */
`timescale 1ns/100ps
module cwg_control
   import cwg_pkg::*;
(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   input  wire logic                   ce,
   // Register port
   input  wire logic [3:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   // Chip state and pins
   input  wire logic                   sleep,
   input  wire logic [NUM_SOURCES-1:0] source_in,
   input  wire logic [NUM_SHUT-1:0]    shutdown_in_n,
   output logic      [3:0]             wave_out,
   output logic                        irq
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   cwg_ctrl_t                ctrl;
   cwg_shut_t                shut;
   logic [3:0]               output_invert;
   logic                     clock_source_select;
   logic [3:0]               input_source_select;
   logic [3:0]               steering_select;
   logic [3:0]               steering_data;
   logic [NUM_SHUT-1:0]      shutdown_source_select;
   logic [DELAY_W-1:0]       rising_delay_count;
   logic [DELAY_W-1:0]       falling_delay_count;
   logic [DELAY_W-1:0]       rise_active;
   logic [DELAY_W-1:0]       fall_active;
   logic [1:0]               irq_status;
   logic [1:0]               irq_mask;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   localparam int SW = NUM_SOURCES + NUM_SHUT;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic [SW-1:0] sync3;
   logic [SW-1:0] filt;

   // Three stages; a bit moves only when stages two and three agree
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         filt  <= '0;
      end else if (ce) begin
         sync1 <= {shutdown_in_n, source_in};
         sync2 <= sync1;
         sync3 <= sync2;
         filt  <= (sync2 & sync3) | (filt & (sync2 | sync3));
      end
   end

   logic data_lvl;
   logic data_q;
   logic shut_req;
   logic data_rise;
   logic data_fall;

   // Reserved source codes read as a constant low input
   assign data_lvl = (input_source_select < 4'(NUM_SOURCES)) ?
                     filt[input_source_select] : 1'b0;
   // Pins are active low; only enabled sources count
   assign shut_req = |(~filt[SW-1:NUM_SOURCES] & shutdown_source_select);
   assign data_rise = data_lvl & ~data_q;
   assign data_fall = ~data_lvl & data_q;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   logic wr_ctrl0;
   logic wr_shut0;
   logic en_rise;
   logic load_now;
   assign wr_ctrl0 = reg_wr && reg_addr == ADDR_CONTROL_ZERO;
   assign wr_shut0 = reg_wr && reg_addr == ADDR_SHUTDOWN_ZERO;
   assign en_rise  = wr_ctrl0 && reg_wdata[BIT_ENABLE] && !ctrl.enable;

   // Plain configuration fields
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl.enable            <= 1'b0;
         ctrl.mode              <= MODE_STEER;
         output_invert          <= '0;
         clock_source_select    <= 1'b0;
         input_source_select    <= '0;
         steering_select        <= '0;
         steering_data          <= '0;
         shut.restart           <= 1'b0;
         shut.override_level_second_pair <= '0;
         shut.override_level_first_pair  <= '0;
         shutdown_source_select <= '0;
         rising_delay_count     <= '0;
         falling_delay_count    <= '0;
         irq_mask               <= '0;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            ADDR_CONTROL_ZERO: begin
               ctrl.enable <= reg_wdata[BIT_ENABLE];
               ctrl.mode   <= reg_wdata[2:0];
            end
            ADDR_CONTROL_ONE:   output_invert <= reg_wdata[3:0];
            ADDR_CLOCK_SELECT:  clock_source_select <= reg_wdata[0];
            ADDR_SOURCE_SELECT: input_source_select <= reg_wdata[3:0];
            ADDR_STEERING: begin
               steering_data   <= reg_wdata[7:4];
               steering_select <= reg_wdata[3:0];
            end
            ADDR_SHUTDOWN_ZERO: begin
               shut.restart <= reg_wdata[BIT_RESTART];
               shut.override_level_second_pair <= reg_wdata[5:4];
               shut.override_level_first_pair  <= reg_wdata[3:2];
            end
            ADDR_SHUTDOWN_ONE:
               shutdown_source_select <= reg_wdata[NUM_SHUT-1:0];
            ADDR_RISING_DELAY:  rising_delay_count  <= reg_wdata[5:0];
            ADDR_FALLING_DELAY: falling_delay_count <= reg_wdata[5:0];
            ADDR_IRQ_MASK:      irq_mask <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Delay double buffer and load request
   // ****************************************************************
   logic fall_seen;

   // Request is refused unless enable was already set before this write
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl.buffer_load_request <= 1'b0;
      end else if (ce) begin
         if (!ctrl.enable || load_now)
            ctrl.buffer_load_request <= 1'b0;
         else if (wr_ctrl0)
            ctrl.buffer_load_request <= reg_wdata[BIT_LOAD];
      end
   end

   // Track the first falling edge after the request
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         fall_seen <= 1'b0;
      else if (ce) begin
         if (!ctrl.buffer_load_request || load_now)
            fall_seen <= 1'b0;
         else if (data_fall)
            fall_seen <= 1'b1;
      end
   end

   assign load_now = ctrl.enable && ctrl.buffer_load_request &&
                     fall_seen && data_rise;

   // Disabled: buffers follow writes; enabled: copy on load only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rise_active <= '0;
         fall_active <= '0;
      end else if (ce) begin
         if (!ctrl.enable || load_now) begin
            rise_active <= rising_delay_count;
            fall_active <= falling_delay_count;
         end
      end
   end

   // ****************************************************************
   // Shutdown state and restart
   // ****************************************************************
   logic shut_clear;
   logic next_shutdown;
   logic running;

   // A live source blocks both software and automatic clearing
   assign shut_clear = !shut_req &&
                       (shut.restart || (wr_shut0 && !reg_wdata[BIT_SHUTDOWN]));
   assign next_shutdown = shut_req || en_rise ||
                          (wr_shut0 && reg_wdata[BIT_SHUTDOWN]) ||
                          (shut.shutdown && !shut_clear);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         shut.shutdown <= 1'b0;
      else if (ce)
         shut.shutdown <= next_shutdown;
   end

   // Generation resumes at the first data rise after shutdown clears
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         running <= 1'b0;
      else if (ce) begin
         if (!ctrl.enable || shut.shutdown)
            running <= 1'b0;
         else if (data_rise)
            running <= 1'b1;
      end
   end

   // ****************************************************************
   // Dead-band counters
   // ****************************************************************
   logic              db_tick;
   logic [DELAY_W:0]  rise_cnt;
   logic [DELAY_W:0]  fall_cnt;
   logic              rise_done;
   logic              fall_done;
   logic              phase;

   // In sleep only the fast oscillator keeps the counters ticking
   assign db_tick   = !sleep || clock_source_select;
   assign rise_done = rise_cnt >= {1'b0, rise_active};
   assign fall_done = fall_cnt >= {1'b0, fall_active};

   // Both counters restart at their own edge of the data input
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         data_q   <= 1'b0;
         rise_cnt <= '0;
         fall_cnt <= '0;
         phase    <= 1'b0;
      end else if (ce) begin
         data_q <= data_lvl;
         if (data_rise) begin
            rise_cnt <= '0;
            phase    <= ~phase;
         end else if (db_tick && !rise_done)
            rise_cnt <= rise_cnt + 7'h01;
         if (data_fall)
            fall_cnt <= '0;
         else if (db_tick && !fall_done)
            fall_cnt <= fall_cnt + 7'h01;
      end
   end

   // ****************************************************************
   // Output shaping
   // ****************************************************************
   function automatic logic level_of(input logic [1:0] code,
                                     input logic       inv);
      // Forced levels ignore polarity; others give the inactive level
      if (code == LEVEL_HIGH)
         level_of = 1'b1;
      else if (code == LEVEL_LOW)
         level_of = 1'b0;
      else
         level_of = inv;
   endfunction

   logic [3:0] wave;
   logic [3:0] next_out;

   // Mode decode; reserved codes keep every output inactive
   always_comb begin
      wave = 4'h0;
      case (ctrl.mode)
         MODE_STEER, MODE_STEER_SYNC:
            for (int i = 0; i < 4; i++)
               wave[i] = steering_select[i] ? data_lvl : steering_data[i];
         MODE_FB_FWD: begin
            wave[0] = 1'b1;
            wave[3] = data_lvl & fall_done;
         end
         MODE_FB_REV: begin
            wave[2] = 1'b1;
            wave[1] = data_lvl & rise_done;
         end
         MODE_HALF: begin
            wave[0] = data_lvl & rise_done;
            wave[1] = ~data_lvl & fall_done;
            wave[2] = wave[0];
            wave[3] = wave[1];
         end
         MODE_PUSH_PULL: begin
            wave[0] = data_lvl & phase;
            wave[1] = data_lvl & ~phase;
            wave[2] = wave[0];
            wave[3] = wave[1];
         end
         default: wave = 4'h0;
      endcase
   end

   // Shutdown drives override pairs: A/C first pair, B/D second pair
   always_comb begin
      if (!ctrl.enable)
         next_out = output_invert;
      else if (shut.shutdown || !running) begin
         next_out[0] = level_of(shut.override_level_first_pair,
                                output_invert[0]);
         next_out[2] = level_of(shut.override_level_first_pair,
                                output_invert[2]);
         next_out[1] = level_of(shut.override_level_second_pair,
                                output_invert[1]);
         next_out[3] = level_of(shut.override_level_second_pair,
                                output_invert[3]);
      end else
         next_out = wave ^ output_invert;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         wave_out <= 4'h0;
      else if (ce)
         wave_out <= next_out;
   end

   // ****************************************************************
   // Interrupts and read data
   // ****************************************************************
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   assign irq_set[BIT_EVT_SHUT] = next_shutdown && !shut.shutdown;
   assign irq_set[BIT_EVT_LOAD] = load_now;
   assign irq_clr = (reg_wr && reg_addr == ADDR_IRQ_STATUS) ?
                    reg_wdata[1:0] : 2'h0;

   // New events win over a write-one-to-clear in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status <= '0;
         irq        <= 1'b0;
      end else if (ce) begin
         irq_status <= irq_set | (irq_status & ~irq_clr);
         irq        <= |((irq_set | (irq_status & ~irq_clr)) & irq_mask);
      end
   end

   // Answer one cycle after the address, with or without the read strobe; unmapped reads give zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         reg_rdata <= RESET_REG;
      else if (ce) begin
         case (reg_addr)
            ADDR_CONTROL_ZERO:  reg_rdata <= {ctrl.enable,
                                   ctrl.buffer_load_request, 3'h0,
                                   ctrl.mode};
            ADDR_CONTROL_ONE:   reg_rdata <= {2'h0, data_lvl, 1'b0,
                                   output_invert};
            ADDR_CLOCK_SELECT:  reg_rdata <= {7'h00, clock_source_select};
            ADDR_SOURCE_SELECT: reg_rdata <= {4'h0, input_source_select};
            ADDR_STEERING:      reg_rdata <= {steering_data, steering_select};
            ADDR_SHUTDOWN_ZERO: reg_rdata <= {shut, 2'h0};
            ADDR_SHUTDOWN_ONE:  reg_rdata <= {4'h0, shutdown_source_select};
            ADDR_RISING_DELAY:  reg_rdata <= {2'h0, rising_delay_count};
            ADDR_FALLING_DELAY: reg_rdata <= {2'h0, falling_delay_count};
            ADDR_IRQ_STATUS:    reg_rdata <= {6'h00, irq_status};
            ADDR_IRQ_MASK:      reg_rdata <= {6'h00, irq_mask};
            default:            reg_rdata <= RESET_REG;
         endcase
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_enable_write;
      ce && en_rise;
   endsequence

   a_ld_same_cycle: assert property (
      s_enable_write |=> !ctrl.buffer_load_request)
      else $error("load request taken in the enabling write");
   a_enable_shuts: assert property (
      s_enable_write |=> shut.shutdown)
      else $error("enable did not enter shutdown");
   a_auto_restart: assert property (
      ce && shut.shutdown && shut.restart && !shut_req && !en_rise
      && !wr_shut0 |=> !shut.shutdown)
      else $error("auto restart did not clear shutdown");
   a_source_holds: assert property (
      ce && shut_req |=> shut.shutdown)
      else $error("shutdown cleared while source active");
   a_load_clears: assert property (
      ce && load_now |=> !ctrl.buffer_load_request
      && rise_active == $past(rising_delay_count))
      else $error("load did not copy and clear");
   a_readback_in: assert property (
      ce && reg_rd && reg_addr == ADDR_CONTROL_ONE |=>
      reg_rdata[BIT_INPUT_LEVEL] == $past(data_lvl)
      && reg_rdata[4] == 1'b0)
      else $error("input level read back wrong");
   a_reserved_bits: assert property (
      ce && reg_rd && reg_addr == ADDR_CONTROL_ZERO |=>
      reg_rdata[5:3] == 3'h0 && reg_rdata[7] == $past(ctrl.enable))
      else $error("control zero layout wrong");
   a_reserved_mode: assert property (
      ce && ctrl.enable && running && !shut.shutdown
      && ctrl.mode[2:1] == 2'h3 |=> wave_out == $past(output_invert))
      else $error("reserved mode drove an output");
   a_invert_out: assert property (
      ce && ctrl.enable && running && !shut.shutdown |=>
      wave_out == ($past(wave) ^ $past(output_invert)))
      else $error("polarity not applied");
   a_sleep_tick: assert property (
      ce && sleep && clock_source_select && !rise_done && !data_rise
      |=> rise_cnt == $past(rise_cnt) + 7'h01)
      else $error("dead band stalled in sleep");

endmodule // cwg_control

/* File: testbench/cwg_switch_driver.sv */
`timescale 1ns/100ps
// Gate drivers for the power switches behind the four output pins
module cwg_switch_driver (
   // Pin side
   input  wire logic       pin_out_en,
   input  wire logic [3:0] wave_out,
   // Switch side
   output logic      [3:0] gate
);
   // Pulled low while pins are inputs, so no switch fires during setup
   assign gate = pin_out_en ? wave_out : 4'h0;
endmodule // cwg_switch_driver

/* File: testbench/test_complementary_waveform_control.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   bad_count++; $display("Error %s exp %h seen %h", n, e, g); end end
module test_complementary_waveform_control;
   import cwg_pkg::*;
   logic                   core_clk = 1'b0;
   logic                   resetn   = 1'b0;
   logic                   ce       = 1'b1;
   logic                   sleep    = 1'b0;
   logic                   reg_wr   = 1'b0;
   logic                   reg_rd   = 1'b0;
   logic                   pin_en   = 1'b0;
   logic [3:0]             reg_addr = 4'h0;
   logic [7:0]             reg_wdata = 8'h00;
   logic [NUM_SOURCES-1:0] source_in = '0;
   logic [NUM_SHUT-1:0]    shutdown_in_n = '1;
   logic [7:0]             reg_rdata;
   logic [3:0]             wave_out;
   logic [3:0]             gate;
   logic                   irq;
   int                     bad_count = 0;
   int                     checks_done = 0;
   int                     seed = 32;
   int                     m0, m1, m5, m9, lvl, sel, v;

   always #20 core_clk = ~core_clk;

   cwg_control u_cwg_control (.core_clk(core_clk), .resetn(resetn),
      .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sleep(sleep), .source_in(source_in),
      .shutdown_in_n(shutdown_in_n), .wave_out(wave_out), .irq(irq));
   cwg_switch_driver u_cwg_switch_driver (.pin_out_en(pin_en),
      .wave_out(wave_out), .gate(gate));

   // ***********************************************************
   // Register model and bus tasks
   // ***********************************************************
   function automatic logic [7:0] mexp(input logic [3:0] a);
      case (a)
         4'h0: return m0[7:0];
         4'h1: return m1[7:0] | (lvl[0] ? 8'h20 : 8'h00);
         4'h5: return m5[7:0];
         4'h9: return m9[7:0];
         default: return 8'h00;
      endcase
   endfunction

   // The model takes the write first; load needs an earlier enable
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      case (a)
         4'h0: begin
            if (d[7] && !m0[7]) begin
               m5 = m5 | 8'h80;
               m9 = m9 | 8'h01;
            end
            m0 = d & (m0[7] ? 8'hC7 : 8'h87);
         end
         4'h1: m1 = d & 8'h0F;
         4'h5: m5 = d;
         4'h9: m9 = m9 & ~d;
         default: ;
      endcase
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data follow the address one cycle later and stay while it is held
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", mexp(a), reg_rdata)
   endtask

   // Selected data input, given time to cross the synchroniser
   task automatic set_dat(input logic b);
      source_in[3] <= b;
      repeat (6) @(posedge core_clk);
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      m0 = 0; m1 = 0; m5 = 0; m9 = 0; lvl = 0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      rd(4'h0);
      rd(4'h1);
      wr(4'hF, 8'hFF);
      rd(4'hF);
      // Every mode code, with load and spare bits set while disabled
      for (int i = 0; i < 8; i++) begin
         wr(4'h0, 8'h78 | i[7:0]);
         rd(4'h0);
      end
      wr(4'h0, 8'h04);
      // Disabled outputs rest at their invert levels
      repeat (4) begin
         v = $random(seed);
         wr(4'h1, v[7:0]);
         repeat (2) @(posedge core_clk);
         `CHK("wave_out", m1[3:0], wave_out)
      end
      sel = {$random(seed)} % NUM_SOURCES;
      wr(4'h3, sel[7:0]);
      v = $random(seed);
      source_in <= v[NUM_SOURCES-1:0];
      repeat (6) @(posedge core_clk);
      lvl = v[sel];
      rd(4'h1);
      // Setup with pins still inputs, then enable into shutdown
      wr(4'h3, 8'h03);
      lvl = 0;
      set_dat(1'b0);
      wr(4'h1, 8'h05);
      wr(4'h5, 8'h38);
      wr(4'h7, 8'h02);
      wr(4'h8, 8'h02);
      wr(4'h2, 8'h01);
      wr(4'hA, 8'h03);
      `CHK("gate", 4'h0, gate)
      wr(4'h0, 8'hC4);
      rd(4'h0);
      rd(4'h5);
      `CHK("wave_out", 4'hA, wave_out)
      `CHK("irq", 1'b1, irq)
      wr(4'h9, 8'h01);
      rd(4'h9);
      `CHK("irq", 1'b0, irq)
      pin_en <= 1'b1;
      @(posedge core_clk);
      `CHK("gate", 4'hA, gate)
      wr(4'h5, 8'h38);
      rd(4'h5);
      wr(4'h1, 8'h00);
      // Counting goes on in sleep when the fast oscillator clocks it
      sleep <= 1'b1;
      set_dat(1'b1);
      repeat (4) @(posedge core_clk);
      `CHK("wave_out_a", 1'b1, wave_out[0])
      sleep <= 1'b0;
      // Load request waits for a fall and then a rise of the data
      wr(4'h0, 8'hC4);
      rd(4'h0);
      wr(4'h7, 8'h05);
      set_dat(1'b0);
      rd(4'h0);
      set_dat(1'b1);
      m0 = 8'h84;
      m9 = m9 | 8'h02;
      rd(4'h0);
      rd(4'h9);
      `CHK("irq", 1'b1, irq)
      // Auto restart lets the hardware drop the shutdown flag
      wr(4'h0, 8'h04);
      wr(4'h9, 8'h03);
      wr(4'h5, 8'h78);
      wr(4'h0, 8'h84);
      m5 = 8'h78;
      rd(4'h5);
      rd(4'h9);
      // Steering: outputs picked while disabled, then enabled
      wr(4'h0, 8'h04);
      wr(4'h4, 8'hA1);
      wr(4'h0, 8'h80);
      set_dat(1'b0);
      set_dat(1'b1);
      repeat (2) @(posedge core_clk);
      `CHK("wave_out", 4'hB, wave_out)
      set_dat(1'b0);
      repeat (2) @(posedge core_clk);
      `CHK("wave_out", 4'hA, wave_out)
      // Full bridge with data low: only the fixed leg is on
      wr(4'h0, 8'h82);
      repeat (3) @(posedge core_clk);
      `CHK("wave_out", 4'h1, wave_out)
      wr(4'h0, 8'h83);
      repeat (3) @(posedge core_clk);
      `CHK("wave_out", 4'h4, wave_out)
      give_verdict();
   end
endmodule // test_complementary_waveform_control
